// ==== core/ssr_cfg.v ====
`timescale 1ns/1ns
`include "ssr_consts.vh"
// Switch configuration slice: VLAN default, rate cap extension, storm
// protection, forced crossover and reserved multicast handling.
module ssr_cfg #(
    parameter WINDOW_CYCLES = `SSR_WINDOW_CYCLES
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [5:0]  port_link_10m,
    input  wire        bcast_rx,
    output wire        storming,
    output wire        storm_drop,
    output reg  [5:0]  default_vlan_portmap,
    output reg  [2:0]  port5_tx_rate_cap_high,
    output reg  [2:0]  port4_tx_rate_cap_high,
    output reg         port4_crossover_force,
    output reg         port3_crossover_force,
    output reg         port2_crossover_force,
    output reg  [1:0]  bpdu_tx_tag_mode,
    output reg  [1:0]  gxrp_queue_select,
    output reg  [1:0]  slow_group_queue_select,
    output reg  [1:0]  bpdu_queue_select,
    output reg  [5:0]  bpdu_pass_ports,
    output reg  [5:0]  slow_pass_ports,
    output reg  [5:0]  pae_pass_ports,
    output reg  [5:0]  reserved_group0_pass_ports,
    output reg  [5:0]  reserved_group1_pass_ports,
    output reg  [5:0]  gxrp_pass_ports,
    output reg  [5:0]  reserved_group2_pass_ports,
    output reg  [5:0]  reserved_group3_pass_ports
);
    reg  [15:0] vlan_reg;
    reg  [15:0] storm0_reg;
    reg  [15:0] storm1_reg;
    reg  [15:0] rsvd0_reg;
    reg  [31:0] prdata_next;
    wire        aligned;
    wire        hit_vlan;
    wire        hit_storm0;
    wire        hit_storm1;
    wire        hit_rsvd0;
    wire        hit_status;
    wire        mapped;
    wire        wr_en;
    wire        rd_en;
    wire [5:0]  link_10m_s;
    wire [0:0]  bcast_s;
    reg         bcast_d_reg;
    wire [15:0] last_count;

    // Pass bit widens to a full six-port map
    function [5:0] pass_map;
        input bit_in;
        begin
            pass_map = bit_in ? 6'h3F : 6'h00; // RL10
        end
    endfunction

    // Word decode: byte address is index times four
    function hit;
        input [11:0] a;
        input [7:0]  i;
        begin
            hit = (a[9:2] == i) && (a[11:10] == 2'h0);
        end
    endfunction

    assign aligned    = (paddr[1:0] == 2'h0);
    assign hit_vlan   = hit(paddr, `SSR_IDX_VLAN);
    assign hit_storm0 = hit(paddr, `SSR_IDX_STORM0);
    assign hit_storm1 = hit(paddr, `SSR_IDX_STORM1);
    assign hit_rsvd0  = hit(paddr, `SSR_IDX_RSVD0);
    assign hit_status = hit(paddr, `SSR_IDX_STATUS);
    assign mapped     = aligned & (hit_vlan | hit_storm0 | hit_storm1 |
                                   hit_rsvd0 | hit_status);

    // Zero wait states; unmapped or misaligned access errors
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en   = psel & penable & pwrite & mapped;
    // Read decode runs in the setup cycle, one edge ahead of the answer
    assign rd_en   = psel & ~penable & ~pwrite & mapped;

    // Link speed and receive strobe come from the port clock region
    ssr_sync #(
        .W (6)
    ) u_link_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (port_link_10m),
        .dout    (link_10m_s)
    );

    ssr_sync #(
        .W (1)
    ) u_rx_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (bcast_rx),
        .dout    (bcast_s)
    );

    // Rising edge of synchronised level counts one packet
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bcast_d_reg <= 1'b0;
        else
            bcast_d_reg <= bcast_s[0];
    end

    // Register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vlan_reg   <= `SSR_RST_VLAN; // RL7
            storm0_reg <= `SSR_RST_STORM0;
            storm1_reg <= `SSR_RST_STORM1;
            rsvd0_reg  <= `SSR_RST_RSVD0;
        end else if (wr_en) begin
            if (hit_vlan)
                vlan_reg <= pwdata[15:0] & `SSR_VLAN_WMASK;
            if (hit_storm0)
                storm0_reg <= pwdata[15:0] & `SSR_STORM0_WMASK;
            if (hit_storm1)
                storm1_reg <= pwdata[15:0];
            if (hit_rsvd0)
                rsvd0_reg <= pwdata[15:0];
        end
    end

    // Read mux; bits above 15 read zero except in the status word
    always @* begin
        prdata_next = 32'h00000000;
        if (rd_en) begin
            if (hit_vlan)
                prdata_next = {16'h0000, vlan_reg};
            else if (hit_storm0)
                prdata_next = {16'h0000, storm0_reg};
            else if (hit_storm1)
                prdata_next = {16'h0000, storm1_reg};
            else if (hit_rsvd0)
                prdata_next = {16'h0000, rsvd0_reg};
            else if (hit_status)
                prdata_next = {storming, storm_drop, link_10m_s,
                               8'h00, last_count};
        end
    end

    // Read data loaded at the setup edge so it stands through the access
    // cycle; status fields are therefore one cycle old when read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel & ~penable & ~pwrite)
            prdata <= prdata_next;
    end

    // Storm engine fed from the storm registers
    ssr_storm #(
        .WINDOW_CYCLES (WINDOW_CYCLES),
        .CW            (16)
    ) u_storm (
        .pclk       (pclk),
        .presetn    (presetn),
        .storm_en   (storm0_reg[`SSR_STORM_EN_BIT]), // RL1
        .drop_en    (storm0_reg[`SSR_STORM_DROP_BIT]), // RL2
        .fast_limit (storm0_reg[`SSR_STORM_TH_HI:0]), // RL3
        .slow_limit (storm1_reg[`SSR_STORM_TH_HI:0]), // RL4
        .any_slow   (|link_10m_s), // RL4
        .pkt_seen   (bcast_s[0] & ~bcast_d_reg), // RL5
        .storming   (storming),
        .drop_req   (storm_drop),
        .last_count (last_count)
    );

    // Configuration outputs registered from the bank
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            default_vlan_portmap       <= 6'h3F;
            port5_tx_rate_cap_high     <= 3'h0;
            port4_tx_rate_cap_high     <= 3'h0;
            port4_crossover_force      <= 1'b0;
            port3_crossover_force      <= 1'b0;
            port2_crossover_force      <= 1'b0;
            bpdu_tx_tag_mode           <= 2'h0;
            gxrp_queue_select          <= 2'h0;
            slow_group_queue_select    <= 2'h0;
            bpdu_queue_select          <= 2'h0;
            bpdu_pass_ports            <= 6'h3F;
            slow_pass_ports            <= 6'h00;
            pae_pass_ports             <= 6'h3F;
            reserved_group0_pass_ports <= 6'h3F;
            reserved_group1_pass_ports <= 6'h3F;
            gxrp_pass_ports            <= 6'h3F;
            reserved_group2_pass_ports <= 6'h3F;
            reserved_group3_pass_ports <= 6'h3F;
        end else begin
            default_vlan_portmap <=
                vlan_reg[`SSR_VLAN_MAP_HI:`SSR_VLAN_MAP_LO]; // RL7
            port5_tx_rate_cap_high <= vlan_reg[5:3]; // RL8
            port4_tx_rate_cap_high <= vlan_reg[2:0]; // RL8
            port4_crossover_force  <= storm1_reg[`SSR_MDIX4_BIT]; // RL6
            port3_crossover_force  <= storm1_reg[`SSR_MDIX3_BIT]; // RL6
            port2_crossover_force  <= storm1_reg[`SSR_MDIX2_BIT]; // RL6
            bpdu_tx_tag_mode        <= rsvd0_reg[15:14]; // RL9
            gxrp_queue_select       <= rsvd0_reg[13:12];
            slow_group_queue_select <= rsvd0_reg[11:10];
            bpdu_queue_select       <= rsvd0_reg[9:8];
            reserved_group3_pass_ports <= pass_map(rsvd0_reg[7]); // RL10
            reserved_group2_pass_ports <= pass_map(rsvd0_reg[6]); // RL10
            gxrp_pass_ports            <= pass_map(rsvd0_reg[5]); // RL10
            reserved_group1_pass_ports <= pass_map(rsvd0_reg[4]); // RL10
            reserved_group0_pass_ports <= pass_map(rsvd0_reg[3]); // RL10
            pae_pass_ports             <= pass_map(rsvd0_reg[2]); // RL10
            slow_pass_ports            <= pass_map(rsvd0_reg[1]); // RL10
            bpdu_pass_ports            <= pass_map(rsvd0_reg[0]); // RL10
        end
    end
endmodule // ssr_cfg

// ==== core/ssr_consts.vh ====
// What this block does
// (RL1) Storm enable set turns storm protection on; clear turns it off.
// (RL2) Drop enable set discards frames while storming; clear never drops.
// (RL3) Fast-link limit is the storm threshold when every port runs 100M.
// (RL4) Slow-link limit is the storm threshold when any port runs 10M.
// (RL5) Count packets per 50 ms window; bound reached when count exceeds limit.
// (RL6) Crossover force bits for ports 2 to 4: 0 selects MDI, 1 MDIX.
// (RL7) Six-bit default VLAN portmap, one bit per port, resets to all members.
// (RL8) Hold bits 10 to 8 of port 5 and port 4 transmit rate caps.
// (RL9) BPDU tag mode: default, unmodified, always tagged, always untagged.
// (RL10) Each reserved class pass bit gives an all-zero or all-ones map.
// (RL11) Limit tracks links; per-window count; storm ends on a clean window.
`ifndef SSR_CONSTS_VH
`define SSR_CONSTS_VH

// Register indices; byte address is four times the index
`define SSR_IDX_VLAN        8'h3A
`define SSR_IDX_STORM0      8'h3B
`define SSR_IDX_STORM1      8'h3C
`define SSR_IDX_RSVD0       8'h3D
`define SSR_IDX_STATUS      8'h3F

// Reset values
`define SSR_RST_VLAN        16'h0FC0
`define SSR_RST_STORM0      16'h0000
`define SSR_RST_STORM1      16'h0000
`define SSR_RST_RSVD0       16'h00FD

// Field positions
`define SSR_VLAN_MAP_HI     11
`define SSR_VLAN_MAP_LO     6
`define SSR_STORM_DROP_BIT  14
`define SSR_STORM_EN_BIT    13
`define SSR_STORM_TH_HI     12
`define SSR_MDIX4_BIT       15
`define SSR_MDIX3_BIT       14
`define SSR_MDIX2_BIT       13
`define SSR_VLAN_WMASK      16'hFFFF
`define SSR_STORM0_WMASK    16'h7FFF

// Storm window timing
`define SSR_WINDOW_MS       50
`define SSR_CLK_MHZ         125
`define SSR_WINDOW_CYCLES   (`SSR_WINDOW_MS * 1000 * `SSR_CLK_MHZ)

`endif

// ==== core/ssr_sync.v ====
`timescale 1ns/1ns
// Two-flop synchroniser for a bus of independent level signals
module ssr_sync #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    // First stage feeds only the second stage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= {W{1'b0}};
            sync_reg <= {W{1'b0}};
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
        end
    end
    assign dout = sync_reg;
endmodule // ssr_sync

// ==== core/ssr_storm.v ====
`timescale 1ns/1ns
`include "ssr_consts.vh"
// Broadcast storm monitor: per-window packet count against a threshold
module ssr_storm #(
    parameter WINDOW_CYCLES = `SSR_WINDOW_CYCLES,
    parameter CW            = 16
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        storm_en,
    input  wire        drop_en,
    input  wire [12:0] fast_limit,
    input  wire [12:0] slow_limit,
    input  wire        any_slow,
    input  wire        pkt_seen,
    output reg         storming,
    output wire        drop_req,
    output reg  [CW-1:0] last_count
);
    reg  [31:0]   tick_reg;
    reg  [CW-1:0] cnt_reg;
    wire [12:0]   limit;
    wire          win_end;
    wire [CW-1:0] cnt_inc;
    wire [CW-1:0] cnt_fin;

    // Count against a 13-bit limit, widened on purpose
    function over;
        input [CW-1:0] c;
        input [12:0]   l;
        begin
            over = (c > {{(CW-13){1'b0}}, l});
        end
    endfunction

    // Limit tracks current link speeds every cycle
    assign limit   = any_slow ? slow_limit : fast_limit; // RL3 RL4 RL11
    assign win_end = (tick_reg == WINDOW_CYCLES - 1);
    // Saturate so a flood cannot wrap the count below threshold
    assign cnt_inc = (&cnt_reg) ? cnt_reg : cnt_reg + {{(CW-1){1'b0}}, 1'b1};
    // Closing count includes a packet seen in the last cycle
    assign cnt_fin = pkt_seen ? cnt_inc : cnt_reg;

    // Window timer, packet counter and storming state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg   <= 32'h00000000;
            cnt_reg    <= {CW{1'b0}};
            storming   <= 1'b0;
            last_count <= {CW{1'b0}};
        end else if (!storm_en) begin // RL1
            tick_reg <= 32'h00000000;
            cnt_reg  <= {CW{1'b0}};
            storming <= 1'b0;
        end else if (win_end) begin
            tick_reg   <= 32'h00000000;
            cnt_reg    <= {CW{1'b0}}; // RL11
            last_count <= cnt_fin;
            // Storm carries on unless the closing window stayed in limit
            storming   <= over(cnt_fin, limit); // RL11
        end else begin
            tick_reg <= tick_reg + 32'h00000001; // RL5
            if (pkt_seen)
                cnt_reg <= cnt_inc;
            if (over(cnt_reg, limit))
                storming <= 1'b1; // RL5
        end
    end

    assign drop_req = storm_en & drop_en & storming; // RL2
endmodule // ssr_storm

// ==== sim/ssr_cfg_monitor.sv ====
`timescale 1ns/1ns
// Port checks: config fields, refusal and storm gating
module ssr_cfg_monitor (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    input wire        storming,
    input wire        storm_drop,
    input wire [5:0]  default_vlan_portmap,
    input wire [2:0]  port5_tx_rate_cap_high,
    input wire [2:0]  port4_tx_rate_cap_high,
    input wire        port4_crossover_force,
    input wire        port3_crossover_force,
    input wire        port2_crossover_force,
    input wire [1:0]  bpdu_tx_tag_mode,
    input wire [5:0]  gxrp_pass_ports
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] wd1, wd2;
    logic        drop_trk;
    wire         wr = psel && penable && pwrite;
    // Two edges of delay cover either output latency
    always @(posedge pclk) begin
        wd1 <= pwdata;
        wd2 <= wd1;
    end
    // Both storm enables as last written by the host
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            drop_trk <= 1'b0;
        else if (wr && paddr == 12'h0EC)
            drop_trk <= pwdata[14] & pwdata[13];
    end
    vlan_map_a: assert property (
        wr && paddr == 12'h0E8 |-> ##2 default_vlan_portmap == wd2[11:6])
        else $error("Vlan map wrong");
    rate_cap_a: assert property (
        wr && paddr == 12'h0E8 |-> ##2 {port5_tx_rate_cap_high,
        port4_tx_rate_cap_high} == wd2[5:0]) else $error("Rate cap wrong");
    xover_bits_a: assert property (
        wr && paddr == 12'h0F0 |-> ##2 {port4_crossover_force,
        port3_crossover_force, port2_crossover_force} == wd2[15:13])
        else $error("Crossover wrong");
    tag_mode_a: assert property (
        wr && paddr == 12'h0F4 |-> ##2 bpdu_tx_tag_mode == wd2[15:14])
        else $error("Tag mode wrong");
    gxrp_map_a: assert property (
        wr && paddr == 12'h0F4 |-> ##2 gxrp_pass_ports == {6{wd2[5]}})
        else $error("Pass map wrong");
    drop_gate_a: assert property (
        storm_drop == (storming && drop_trk)) else $error("Drop gate wrong");
    storm_off_a: assert property (
        wr && paddr == 12'h0EC && !pwdata[13] |-> ##4 !storming [*4])
        else $error("Storm while off");
    bad_addr_a: assert property (psel && penable && !(paddr inside
        {12'h0E8, 12'h0EC, 12'h0F0, 12'h0F4, 12'h0FC}) |-> pslverr)
        else $error("No slave error");
endmodule // ssr_cfg_monitor

bind ssr_cfg ssr_cfg_monitor mon_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .storming(storming),
    .storm_drop(storm_drop), .default_vlan_portmap(default_vlan_portmap),
    .port5_tx_rate_cap_high(port5_tx_rate_cap_high),
    .port4_tx_rate_cap_high(port4_tx_rate_cap_high),
    .port4_crossover_force(port4_crossover_force),
    .port3_crossover_force(port3_crossover_force),
    .port2_crossover_force(port2_crossover_force),
    .bpdu_tx_tag_mode(bpdu_tx_tag_mode), .gxrp_pass_ports(gxrp_pass_ports));

// ==== sim/ssr_host.sv ====
`timescale 1ns/1ns
// Management host: APB master, waits as long as pready asks
module ssr_host (
    input  wire         pclk,
    input  wire         pready,
    input  wire         pslverr,
    input  wire  [31:0] prdata,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Released data is inverted so stale values never pass
    task automatic xfer(input [11:0] a, input w, input [31:0] x,
                        output [31:0] q, output e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= x;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~x;
    endtask
endmodule // ssr_host

// ==== sim/ssr_cfg_bench.sv ====
`timescale 1ns/1ns
// Register and storm tests through the host model
module ssr_cfg_bench;
    logic        pclk, presetn, bcast;
    logic [5:0]  link10;
    logic [33:0] expq[$], n;
    logic [31:0] d, v;
    int          fails, checked;
    wire         psel, penable, pwrite, pready, pslverr, storming, sdrop;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    wire  [5:0]  vmap, bp, sp, pp, g0, g1, gp, g2, g3;
    wire  [2:0]  c5, c4;
    wire         x4, x3, x2;
    wire  [1:0]  tag, qg, qs, qb;
    wire  [47:0] pall = {g3, g2, gp, g1, g0, pp, sp, bp};
    ssr_host host_u (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    ssr_cfg #(.WINDOW_CYCLES(200)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_link_10m(link10), .bcast_rx(bcast),
        .storming(storming), .storm_drop(sdrop),
        .default_vlan_portmap(vmap), .port5_tx_rate_cap_high(c5),
        .port4_tx_rate_cap_high(c4), .port4_crossover_force(x4),
        .port3_crossover_force(x3), .port2_crossover_force(x2),
        .bpdu_tx_tag_mode(tag), .gxrp_queue_select(qg),
        .slow_group_queue_select(qs), .bpdu_queue_select(qb),
        .bpdu_pass_ports(bp), .slow_pass_ports(sp), .pae_pass_ports(pp),
        .reserved_group0_pass_ports(g0), .reserved_group1_pass_ports(g1),
        .gxrp_pass_ports(gp), .reserved_group2_pass_ports(g2),
        .reserved_group3_pass_ports(g3));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // Notes the expected answer, then runs the bus cycle
    task automatic xfer(input [11:0] a, input w, input [31:0] x);
        logic [31:0] q;
        logic        e, b;
        b = !(a inside {12'h0E8, 12'h0EC, 12'h0F0, 12'h0F4, 12'h0FC});
        expq.push_back({~w, b, b ? 32'h0 : x});
        host_u.xfer(a, w, x, q, e);
    endtask
    task automatic pulses();
        repeat (8) begin
            bcast <= 1'b1;
            tick(2);
            bcast <= 1'b0;
            tick(2);
        end
    endtask
    // Bounded wait; the caller compares afterwards
    task automatic seek();
        for (int k = 0; k < 40 && storming !== 1'b1; k++) tick(1);
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Oldest note against each completed access
    always @(posedge pclk) begin
        if (psel && penable && pready && expq.size() > 0) begin
            n = expq.pop_front();
            chk(pslverr === n[32], "slave error");
            if (n[33]) chk(prdata === n[31:0], "read data");
        end
    end
    initial begin
        #400000;
        fails++;
        tally_and_finish();
    end
    initial begin
        presetn = 1'b0;
        bcast = 1'b0;
        link10 = 6'h00;
        void'($urandom(32'h29E9));
        tick(8);
        presetn <= 1'b1;
        xfer(12'h0E8, 0, 32'h0FC0);
        xfer(12'h0EC, 0, 32'h0000);
        xfer(12'h0F0, 0, 32'h0000);
        xfer(12'h0F4, 0, 32'h00FD);
        xfer(12'h0FC, 0, 32'h0000);
        chk(vmap === 6'h3F && sp === 6'h00 && bp === 6'h3F, "resets");
        $display("Test reset done");
        v = $urandom & 32'hFFFF;
        xfer(12'h0E8, 1, v);
        xfer(12'h0E9, 1, 32'h0);
        xfer(12'h100, 0, 32'h0);
        xfer(12'h0E8, 0, v);
        chk({vmap, c5, c4} === v[11:0], "vlan and caps");
        d = $urandom & 32'hDFFF;
        xfer(12'h0EC, 1, d);
        xfer(12'h0EC, 0, d & 32'h7FFF);
        xfer(12'h0F0, 1, d);
        xfer(12'h0F0, 0, d);
        tick(2);
        chk({x4, x3, x2} === d[15:13], "crossover");
        $display("Test fields done");
        for (int m = 0; m < 4; m++) begin
            d = {m[1:0], 14'($urandom)};
            xfer(12'h0F4, 1, d);
            xfer(12'h0F4, 0, d);
            tick(2);
            chk({tag, qg, qs, qb} === d[15:8], "tag and queues");
            for (int i = 0; i < 8; i++)
                chk(pall[i*6 +: 6] === {6{d[i]}}, "pass map");
        end
        $display("Test reserved done");
        xfer(12'h0EC, 1, 32'h6003);
        pulses();
        seek();
        chk(storming === 1'b1, "fast storm");
        chk(sdrop === 1'b1, "drop on");
        xfer(12'h0EC, 1, 32'h2003);
        tick(2);
        chk(sdrop === 1'b0, "drop off");
        // Past the first window end; that window closed over the limit
        tick(200);
        chk(storming === 1'b1, "storm carries");
        xfer(12'h0F0, 1, 32'h1FFF);
        link10 <= 6'h01 << ($urandom % 6);
        tick(420);
        pulses();
        tick(6);
        chk(storming === 1'b0, "slow limit high");
        // Status: quiet, synced link bits, last closed window empty
        xfer(12'h0FC, 0, {2'b00, link10, 24'h000000});
        xfer(12'h0F0, 1, 32'h0003);
        pulses();
        seek();
        chk(storming === 1'b1, "slow limit low");
        xfer(12'h0EC, 1, 32'h0003);
        tick(6);
        chk(storming === 1'b0, "storm off");
        $display("Test storm done");
        tally_and_finish();
    end
endmodule // ssr_cfg_bench
